// ### include/hsp_pkg.sv
// package: constants and types shared by the host slave port files
package hsp_pkg;
  localparam int ADDR_W = 17;
  localparam int BUS_W = 16;
  localparam int WORD_W = 24;
  localparam int BUF_W = 32;
  localparam int PAGE_W = 9;
  localparam int IOPG_W = 6;
  localparam int DMA_W = 16;
  // positions in the synchronised control vector
  localparam int CTL_ALE = 0;
  localparam int CTL_RD = 1;
  localparam int CTL_WR = 2;
  localparam int CTL_MSN = 3;
  localparam int CTL_ION = 4;
  localparam int CTL_ACKP = 5;
  localparam int CTL_ALEM = 6;
  localparam int CTL_SPOL = 7;
  localparam int CTL_W = 8;
  // start-up: straps caught at STRAP_AT, pins used from RDY_WAIT on
  localparam logic [1:0] STRAP_AT = 2'h2;
  localparam logic [1:0] RDY_WAIT = 2'h3;
  localparam logic [1:0] SP_MEM = 2'h0;
  localparam logic [1:0] SP_BOOT = 2'h1;
  localparam logic [1:0] SP_IO = 2'h2;
  // pieces per packet and first lane used
  localparam logic [2:0] NP_B8_T16 = 3'h2;
  localparam logic [2:0] NP_B16_T16 = 3'h1;
  localparam logic [2:0] NP_B8_T24_3 = 3'h3;
  localparam logic [2:0] NP_B8_T24_4 = 3'h4;
  localparam logic [2:0] NP_B16_T24 = 3'h2;
  localparam logic [2:0] FIRST_3B = 3'h1;
  localparam logic [2:0] FIRST_STD = 3'h0;
  // reset values and the blocked i/o page
  localparam logic RST_BUS16 = 1'b0;
  localparam logic RST_TYPE24 = 1'b0;
  localparam logic RST_STROBE_LOW = 1'b1;
  localparam logic RST_ALE_QUAL = 1'b0;
  localparam logic [8:0] RST_PAGE = 9'h000;
  localparam logic [5:0] RST_IOPG = 6'h01;
  localparam logic [5:0] IOPG_BLOCKED = 6'h00;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_WAIT} hsp_st_t;
  typedef enum logic [1:0] {PD_NONE, PD_IDLE, PD_WR, PD_RD} hsp_pend_t;
endpackage

// ### verilog/hsp_sync.sv
// two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module hsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else if (ce_in) begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule

// ### verilog/hsp_pack_buf.sv
// packet buffer: byte or halfword lanes, whole-word load
`timescale 1ns/1ns
module hsp_pack_buf (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic wide_in,
  input wire logic [1:0] lane_in,
  input wire logic pw_in,
  input wire logic [hsp_pkg::BUS_W-1:0] pd_in,
  input wire logic ld_in,
  input wire logic [hsp_pkg::BUF_W-1:0] ld_data_in,
  output logic [hsp_pkg::BUF_W-1:0] q_out,
  output logic [hsp_pkg::BUS_W-1:0] piece_out
);
  logic [hsp_pkg::BUF_W-1:0] buf_reg;
  logic [hsp_pkg::BUF_W-1:0] buf_next;
  wire [4:0] sh = wide_in ? {lane_in[0], 4'h0} : {lane_in, 3'h0};
  wire [hsp_pkg::BUF_W-1:0] lane_mask =
    (wide_in ? 32'h0000ffff : 32'h000000ff) << sh;
  wire [hsp_pkg::BUF_W-1:0] lane_data = {16'h0000, pd_in} << sh;
  wire [hsp_pkg::BUF_W-1:0] rd_shift = buf_reg >> sh;

  // a load from the internal side takes priority over a host piece
  assign buf_next = ld_in ? ld_data_in :
    (pw_in ? ((buf_reg & ~lane_mask) | (lane_data & lane_mask)) : buf_reg);
  assign piece_out = wide_in ? rd_shift[15:0] : {8'h00, rd_shift[7:0]};
  assign q_out = buf_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_reg <= '0;
    end else if (ce_in) begin
      buf_reg <= buf_next;
    end
  end
endmodule

// ### verilog/hsp_host_slave_port.sv
// host slave port: pin protocol, packing, dma and internal access
`timescale 1ns/1ns
module hsp_host_slave_port #(
  parameter int PAGE_W = hsp_pkg::PAGE_W,
  parameter int IOPG_W = hsp_pkg::IOPG_W,
  parameter int DMA_W = hsp_pkg::DMA_W
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic [hsp_pkg::BUS_W-1:0] MUX_ADDR_DATA_BUS_IN,
  output logic [hsp_pkg::BUS_W-1:0] MUX_ADDR_DATA_BUS_OUT,
  output logic MUX_ADDR_DATA_BUS_OE_OUT,
  input wire logic ADDR_MSB_IN,
  input wire logic ACK_POLARITY_IN,
  input wire logic ADDR_LATCH_IN,
  input wire logic READ_STROBE_IN,
  input wire logic WRITE_STROBE_IN,
  input wire logic MEMORY_SPACE_SELECT_N_IN,
  input wire logic IO_SPACE_SELECT_N_IN,
  input wire logic ALE_QUALIFIER_STRAP_IN,
  input wire logic STROBE_LOW_STRAP_IN,
  output logic ACCESS_READY_ACK_OUT,
  input wire logic CFG_WR_IN,
  input wire logic CFG_BUS16_IN,
  input wire logic CFG_TYPE24_IN,
  input wire logic CFG_PACK4_IN,
  input wire logic CFG_BIG_ENDIAN_IN,
  input wire logic CFG_MSB_FIRST_IN,
  input wire logic CFG_BOOT_IN,
  input wire logic CFG_DMA_MODE_IN,
  input wire logic [PAGE_W-1:0] CFG_PAGE_IN,
  input wire logic [IOPG_W-1:0] CFG_IO_PAGE_IN,
  input wire logic DMA_LOAD_IN,
  input wire logic [hsp_pkg::BUS_W-1:0] DMA_ADDR_IN,
  input wire logic [DMA_W-1:0] DMA_COUNT_IN,
  output logic DMA_BUSY_OUT,
  output logic BUS16_OUT,
  output logic STRAP_ALE_QUAL_OUT,
  output logic STRAP_STROBE_LOW_OUT,
  output logic REFUSED_OUT,
  output logic INT_REQ_OUT,
  output logic INT_WE_OUT,
  output logic [1:0] INT_SPACE_OUT,
  output logic [PAGE_W+hsp_pkg::BUS_W-1:0] INT_ADDR_OUT,
  output logic [hsp_pkg::WORD_W-1:0] INT_WDATA_OUT,
  input wire logic INT_GNT_IN,
  input wire logic INT_DONE_IN,
  input wire logic [hsp_pkg::WORD_W-1:0] INT_RDATA_IN,
  output logic CORE_STALL_OUT
);
  logic [hsp_pkg::ADDR_W-1:0] pin_s;
  logic [hsp_pkg::CTL_W-1:0] ctl_s;
  logic [1:0] rdy_cnt_reg;
  logic strap_qual_reg, strap_low_reg;
  logic rd_prev_reg, wr_prev_reg, ale_prev_reg, sel_prev_reg;
  logic bus16_reg, type24_reg, pack4_reg, big_reg, msbf_reg;
  logic boot_reg, dma_reg;
  logic [PAGE_W-1:0] page_reg;
  logic [IOPG_W-1:0] iopg_reg;
  logic [hsp_pkg::ADDR_W-1:0] haddr_reg;
  logic [hsp_pkg::BUS_W-1:0] dma_addr_reg;
  logic [DMA_W-1:0] dma_cnt_reg;
  logic [2:0] cnt_reg;
  logic [1:0] rpos_reg;
  hsp_pkg::hsp_pend_t pend_reg, pend_next;
  hsp_pkg::hsp_st_t st_reg, st_next;
  logic we_reg, wtype_reg, stall_reg, refused_reg;
  logic ack_rdy_reg, ld_prev_reg, oe_reg;
  logic [1:0] space_reg;
  logic [PAGE_W+hsp_pkg::BUS_W-1:0] addr_reg;
  logic [hsp_pkg::WORD_W-1:0] wdata_reg;
  logic [hsp_pkg::BUS_W-1:0] dout_reg;
  logic [hsp_pkg::BUF_W-1:0] buf_q;
  logic [hsp_pkg::BUS_W-1:0] buf_piece;

  hsp_sync #(.W(hsp_pkg::ADDR_W)) u_sync_bus (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .d_in({ADDR_MSB_IN, MUX_ADDR_DATA_BUS_IN}),
    .q_out(pin_s)
  );
  hsp_sync #(.W(hsp_pkg::CTL_W)) u_sync_ctl (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .d_in({STROBE_LOW_STRAP_IN, ALE_QUALIFIER_STRAP_IN, ACK_POLARITY_IN,
      IO_SPACE_SELECT_N_IN, MEMORY_SPACE_SELECT_N_IN, WRITE_STROBE_IN,
      READ_STROBE_IN, ADDR_LATCH_IN}),
    .q_out(ctl_s)
  );

  // pins are ignored until the synchronisers hold settled values
  wire rdy = rdy_cnt_reg == hsp_pkg::RDY_WAIT;
  wire rd_act = strap_low_reg ? ~ctl_s[hsp_pkg::CTL_RD] :
    ctl_s[hsp_pkg::CTL_RD];
  wire wr_act = strap_low_reg ? ~ctl_s[hsp_pkg::CTL_WR] :
    ctl_s[hsp_pkg::CTL_WR];
  wire ale = ctl_s[hsp_pkg::CTL_ALE];
  wire ms_act = rdy & ~ctl_s[hsp_pkg::CTL_MSN];
  wire io_act = rdy & ~ctl_s[hsp_pkg::CTL_ION];
  wire sel_one = ms_act ^ io_act;
  wire sel_any = ms_act | io_act;
  wire sel_fall = sel_prev_reg & ~sel_any;
  wire rd_rise = rdy & rd_act & ~rd_prev_reg;
  wire wr_rise = rdy & wr_act & ~wr_prev_reg;
  wire qual_cyc = strap_qual_reg & ale;
  // direct mode takes the address cycle
  wire addr_take = ~dma_reg & (strap_qual_reg ?
    (qual_cyc & (rd_rise | wr_rise)) : (rdy & ale_prev_reg & ~ale));
  // work starts only on host strobes
  wire acc_rd = rd_rise & ~qual_cyc;
  wire acc_wr = wr_rise & ~qual_cyc;
  wire acc_any = (acc_rd | acc_wr) & (pend_reg == hsp_pkg::PD_NONE);

  wire t24 = type24_reg & ~io_act;
  // pieces per packet from width and type
  wire [2:0] n_pc = bus16_reg ?
    (t24 ? hsp_pkg::NP_B16_T24 : hsp_pkg::NP_B16_T16) :
    (t24 ? (pack4_reg ? hsp_pkg::NP_B8_T24_4 : hsp_pkg::NP_B8_T24_3) :
    hsp_pkg::NP_B8_T16);
  // three-byte packets skip the pad lane
  wire [2:0] first = (~bus16_reg & t24 & ~pack4_reg) ?
    hsp_pkg::FIRST_3B : hsp_pkg::FIRST_STD;
  wire rev = msbf_reg ^ big_reg;
  wire [2:0] pos_fw = first + cnt_reg;
  wire [2:0] pos_bw = first + n_pc - 3'h1 - cnt_reg;
  wire [1:0] pos = rev ? pos_bw[1:0] : pos_fw[1:0];
  wire pkt_start = cnt_reg == 3'h0;
  wire pkt_last = cnt_reg == (n_pc - 3'h1);

  wire io_blocked = io_act & (iopg_reg == hsp_pkg::IOPG_BLOCKED);
  // an empty count only refuses a new packet, never its later pieces
  wire dma_empty = dma_reg & (dma_cnt_reg == '0) & pkt_start;
  wire refuse = ~sel_one | (dma_reg & io_act) | io_blocked | dma_empty;
  wire take = acc_any & ~refuse;
  wire busy = st_reg != hsp_pkg::ST_IDLE;
  wire launch = (st_reg == hsp_pkg::ST_IDLE) &
    ((pend_reg == hsp_pkg::PD_WR) | (pend_reg == hsp_pkg::PD_RD));
  wire ld = (st_reg == hsp_pkg::ST_WAIT) & INT_DONE_IN & ~we_reg;
  wire [1:0] lane_sel = (take & acc_rd) ? pos : rpos_reg;

  // byte address to word address, bit 0 dropped, bits 1:0 for 24-bit words
  wire [hsp_pkg::BUS_W-1:0] word = dma_reg ? dma_addr_reg :
    (t24 ? {1'b0, haddr_reg[16:2]} : haddr_reg[16:1]);
  wire [1:0] space_now = io_act ? hsp_pkg::SP_IO :
    (boot_reg ? hsp_pkg::SP_BOOT : hsp_pkg::SP_MEM);
  wire [PAGE_W-1:0] pg = io_act ?
    {{(PAGE_W-IOPG_W){1'b0}}, iopg_reg} : page_reg;
  // 24-bit words sit in the upper three bytes
  wire [hsp_pkg::WORD_W-1:0] wdata_now = t24 ? buf_q[31:8] :
    {8'h00, buf_q[15:0]};
  wire [hsp_pkg::BUF_W-1:0] ld_data = wtype_reg ?
    {INT_RDATA_IN, 8'h00} : {16'h0000, INT_RDATA_IN[15:0]};

  // host pieces assembled in the packet buffer
  hsp_pack_buf u_buf (
    .clk_in(CLK_IN),
    .rst_in(RST_IN),
    .ce_in(CE_IN),
    .wide_in(bus16_reg),
    .lane_in(take & acc_wr ? pos : lane_sel),
    .pw_in(take & acc_wr),
    .pd_in(pin_s[hsp_pkg::BUS_W-1:0]),
    .ld_in(ld),
    .ld_data_in(ld_data),
    .q_out(buf_q),
    .piece_out(buf_piece)
  );

  // start reads, last write pieces and, while busy, start writes wait; others are acked at once
  always_comb begin
    pend_next = pend_reg;
    if (sel_fall)
      pend_next = hsp_pkg::PD_NONE;
    else if (take & acc_wr)
      pend_next = pkt_last ? hsp_pkg::PD_WR :
        ((pkt_start & busy) ? hsp_pkg::PD_IDLE : hsp_pkg::PD_NONE);
    else if (take & acc_rd)
      pend_next = pkt_start ? hsp_pkg::PD_RD : hsp_pkg::PD_NONE;
    else if ((pend_reg == hsp_pkg::PD_IDLE) & ~busy)
      pend_next = hsp_pkg::PD_NONE;
    else if (launch & (pend_reg == hsp_pkg::PD_WR))
      pend_next = hsp_pkg::PD_NONE;
    else if ((pend_reg == hsp_pkg::PD_RD) & ld)
      pend_next = hsp_pkg::PD_NONE;
  end

  // request held until the arbiter grants it
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      hsp_pkg::ST_IDLE: if (launch) st_next = hsp_pkg::ST_REQ;
      hsp_pkg::ST_REQ: if (INT_GNT_IN) st_next = hsp_pkg::ST_WAIT;
      hsp_pkg::ST_WAIT: if (INT_DONE_IN) st_next = hsp_pkg::ST_IDLE;
      default: st_next = hsp_pkg::ST_IDLE;
    endcase
  end

  // straps caught once after release, then fixed
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdy_cnt_reg <= '0;
      strap_qual_reg <= hsp_pkg::RST_ALE_QUAL;
      strap_low_reg <= hsp_pkg::RST_STROBE_LOW;
    end else if (CE_IN) begin
      if (!rdy)
        rdy_cnt_reg <= rdy_cnt_reg + 2'h1;
      if (rdy_cnt_reg == hsp_pkg::STRAP_AT) begin
        strap_qual_reg <= ctl_s[hsp_pkg::CTL_ALEM];
        strap_low_reg <= ctl_s[hsp_pkg::CTL_SPOL];
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus16_reg <= hsp_pkg::RST_BUS16;
      type24_reg <= hsp_pkg::RST_TYPE24;
      {pack4_reg, big_reg, msbf_reg, boot_reg, dma_reg} <= '0;
      page_reg <= hsp_pkg::RST_PAGE;
      iopg_reg <= hsp_pkg::RST_IOPG;
    end else if (CE_IN && CFG_WR_IN) begin
      bus16_reg <= CFG_BUS16_IN;
      type24_reg <= CFG_TYPE24_IN;
      {pack4_reg, big_reg, msbf_reg} <=
        {CFG_PACK4_IN, CFG_BIG_ENDIAN_IN, CFG_MSB_FIRST_IN};
      {boot_reg, dma_reg} <= {CFG_BOOT_IN, CFG_DMA_MODE_IN};
      page_reg <= CFG_PAGE_IN;
      iopg_reg <= CFG_IO_PAGE_IN;
    end
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      {rd_prev_reg, wr_prev_reg, ale_prev_reg, sel_prev_reg} <= '0;
      haddr_reg <= '0;
      cnt_reg <= '0;
      rpos_reg <= '0;
      pend_reg <= hsp_pkg::PD_NONE;
    end else if (CE_IN) begin
      {rd_prev_reg, wr_prev_reg} <= {rd_act, wr_act};
      {ale_prev_reg, sel_prev_reg} <= {ale, sel_any};
      pend_reg <= pend_next;
      rpos_reg <= lane_sel;
      if (addr_take)
        haddr_reg <= pin_s;
      if (sel_fall | addr_take)
        cnt_reg <= '0;
      else if (take)
        cnt_reg <= pkt_last ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  // dma address and count step per packet
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      dma_addr_reg <= '0;
      dma_cnt_reg <= '0;
    end else if (CE_IN) begin
      if (DMA_LOAD_IN) begin
        dma_addr_reg <= DMA_ADDR_IN;
        dma_cnt_reg <= DMA_COUNT_IN;
      end else if (launch & dma_reg) begin
        // step after the access has taken the current address
        dma_addr_reg <= dma_addr_reg + 16'h0001;
        dma_cnt_reg <= dma_cnt_reg - 1'b1;
      end
    end
  end

  // one stall pulse per granted memory access
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      st_reg <= hsp_pkg::ST_IDLE;
      {we_reg, wtype_reg, stall_reg, refused_reg} <= '0;
      space_reg <= hsp_pkg::SP_MEM;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (CE_IN) begin
      st_reg <= st_next;
      stall_reg <= (st_reg == hsp_pkg::ST_REQ) & INT_GNT_IN &
        (space_reg != hsp_pkg::SP_IO);
      refused_reg <= acc_any & refuse;
      if (launch) begin
        we_reg <= pend_reg == hsp_pkg::PD_WR;
        wtype_reg <= t24;
        space_reg <= space_now;
        addr_reg <= {pg, word};
        wdata_reg <= wdata_now;
      end
    end
  end

  // bus driven only while read strobe is active
  // ack waits one cycle after a load so data settles first
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      {ack_rdy_reg, ld_prev_reg, oe_reg} <= '0;
      dout_reg <= '0;
    end else if (CE_IN) begin
      ld_prev_reg <= ld;
      ack_rdy_reg <= sel_any & ~ld_prev_reg &
        (pend_reg == hsp_pkg::PD_NONE) & (pend_next == hsp_pkg::PD_NONE);
      oe_reg <= rdy & rd_act & sel_one;
      dout_reg <= buf_piece;
    end
  end

  // ack level follows the polarity pin
  assign ACCESS_READY_ACK_OUT = ctl_s[hsp_pkg::CTL_ACKP] ?
    ack_rdy_reg : ~ack_rdy_reg;
  assign MUX_ADDR_DATA_BUS_OUT = dout_reg;
  assign MUX_ADDR_DATA_BUS_OE_OUT = oe_reg;
  assign INT_REQ_OUT = st_reg == hsp_pkg::ST_REQ;
  assign INT_WE_OUT = we_reg;
  assign INT_SPACE_OUT = space_reg;
  assign INT_ADDR_OUT = addr_reg;
  assign INT_WDATA_OUT = wdata_reg;
  assign CORE_STALL_OUT = stall_reg;
  assign REFUSED_OUT = refused_reg;
  assign DMA_BUSY_OUT = dma_cnt_reg != '0;
  assign BUS16_OUT = bus16_reg;
  assign STRAP_ALE_QUAL_OUT = strap_qual_reg;
  assign STRAP_STROBE_LOW_OUT = strap_low_reg;

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN || !CE_IN);

  a_core_stall: assert property (
    INT_REQ_OUT && INT_GNT_IN && INT_SPACE_OUT != hsp_pkg::SP_IO
    |=> CORE_STALL_OUT ##1 !CORE_STALL_OUT)
    else $error("core stall not a single pulse");
  a_req_held: assert property (
    INT_REQ_OUT && !INT_GNT_IN |=> INT_REQ_OUT && $stable(INT_ADDR_OUT))
    else $error("request dropped before grant");
  a_io_page_zero: assert property (
    INT_REQ_OUT && INT_SPACE_OUT == hsp_pkg::SP_IO
    |-> INT_ADDR_OUT[16 +: IOPG_W] != hsp_pkg::IOPG_BLOCKED)
    else $error("i/o page 0 reached");
  a_dma_no_io: assert property (
    $rose(INT_REQ_OUT) && dma_reg |-> INT_SPACE_OUT != hsp_pkg::SP_IO)
    else $error("dma request to i/o space");
  a_strap_fixed: assert property (
    rdy |=> $stable(strap_qual_reg) && $stable(strap_low_reg))
    else $error("strap changed after start-up");
  a_write_last: assert property (
    take && acc_wr && !pkt_last |=> pend_reg != hsp_pkg::PD_WR)
    else $error("write launched before last piece");
  a_abort_count: assert property (
    sel_fall |=> cnt_reg == 3'h0 && pend_reg == hsp_pkg::PD_NONE)
    else $error("deselect did not end the access");
  a_start_rd_ack: assert property (
    take && acc_rd && pkt_start |=> !ack_rdy_reg [*2])
    else $error("start read acked too early");
  a_width_hold: assert property (
    !$past(CFG_WR_IN) |-> $stable(bus16_reg))
    else $error("bus width changed without a write");
  a_oe_read: assert property (
    MUX_ADDR_DATA_BUS_OE_OUT |-> $past(rd_act))
    else $error("bus driven without read strobe");
  c_read_pkt: cover property (take && acc_rd && pkt_last && !pkt_start);
  c_wr_launch: cover property (launch && pend_reg == hsp_pkg::PD_WR);
  c_dma_pkt: cover property (take && dma_reg && pkt_last);
endmodule

// ### bench/hsp_host_model.sv
// host model: external bus master driving the pin side
`timescale 1ns/1ns
module hsp_host_model (
  input wire logic clk_in,
  input wire logic ack_in,
  input wire logic pol_in,
  input wire logic [15:0] bus_in,
  output logic [15:0] drv_out,
  output logic msb_out,
  output logic ale_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic ms_n_out,
  output logic io_n_out,
  output logic to_out
);
  initial begin
    {drv_out, msb_out, ale_out, to_out} = '0;
    {rd_n_out, wr_n_out, ms_n_out, io_n_out} = 4'hf;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic sel(input logic ms, input logic io);
    ms_n_out <= ~ms;
    io_n_out <= ~io;
    hold(3);
  endtask
  task automatic addr(input logic [16:0] a);
    drv_out <= a[15:0];
    msb_out <= a[16];
    ale_out <= 1'b1;
    hold(3);
    ale_out <= 1'b0;
    hold(3);
    // released bus shows a changed level, not the stale address
    drv_out <= ~a[15:0];
    hold(1);
  endtask
  task automatic acc(input logic wr, input logic [15:0] d,
                     output logic [15:0] q);
    int n;
    n = 0;
    drv_out <= d;
    wr_n_out <= ~wr;
    rd_n_out <= wr;
    hold(5);
    while (ack_in !== pol_in && n < 300) begin
      hold(1);
      n++;
    end
    if (n >= 300) to_out <= 1'b1;
    q = bus_in;
    {wr_n_out, rd_n_out} <= 2'h3;
    drv_out <= ~d;
    hold(3);
  endtask
endmodule

// ### bench/host_slave_port_tb.sv
// testbench: host slave port with host model and memory stub
`timescale 1ns/1ns
module host_slave_port_tb;
  logic clk = 0, rst = 1, pol = 1, cwr = 0, b16 = 0, t24 = 0, p4 = 0;
  logic boot = 0, dm = 0, dload = 0, gnt = 0, done = 0, be = 0;
  logic [8:0] page = 9'h000;
  logic [5:0] iopg = 6'h01;
  logic [15:0] daddr = 16'h0000, dcnt = 16'h0000, dout, drv, bus;
  logic [23:0] rdat = 24'h000000, wd, wv;
  logic [24:0] ia, wa;
  logic [1:0] sp;
  logic oe, ack, busy, bo, sale, slow, refd, req, we, stall;
  logic msb, ale, rdn, wrn, msn, ion, to;
  logic [23:0] mem [256];
  logic [7:0] lf = 8'h5b;
  logic [31:0] seed = 32'he157, r;
  int wcnt = 0, scnt = 0, rcnt = 0, num_errors = 0, tests_run = 0;
  int mf[5] = '{0, 0, 1, 0, 0};
  int mn[5] = '{2, 1, 3, 4, 2};

  always #50 clk = ~clk;
  assign bus = oe ? dout : drv;

  hsp_host_slave_port u_dut (
    .CLK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
    .MUX_ADDR_DATA_BUS_IN(bus), .MUX_ADDR_DATA_BUS_OUT(dout),
    .MUX_ADDR_DATA_BUS_OE_OUT(oe), .ADDR_MSB_IN(msb),
    .ACK_POLARITY_IN(pol), .ADDR_LATCH_IN(ale),
    .READ_STROBE_IN(rdn), .WRITE_STROBE_IN(wrn),
    .MEMORY_SPACE_SELECT_N_IN(msn), .IO_SPACE_SELECT_N_IN(ion),
    .ALE_QUALIFIER_STRAP_IN(1'b0), .STROBE_LOW_STRAP_IN(1'b1),
    .ACCESS_READY_ACK_OUT(ack), .CFG_WR_IN(cwr), .CFG_BUS16_IN(b16),
    .CFG_TYPE24_IN(t24), .CFG_PACK4_IN(p4), .CFG_BIG_ENDIAN_IN(be),
    .CFG_MSB_FIRST_IN(1'b0), .CFG_BOOT_IN(boot), .CFG_DMA_MODE_IN(dm),
    .CFG_PAGE_IN(page), .CFG_IO_PAGE_IN(iopg), .DMA_LOAD_IN(dload),
    .DMA_ADDR_IN(daddr), .DMA_COUNT_IN(dcnt), .DMA_BUSY_OUT(busy),
    .BUS16_OUT(bo), .STRAP_ALE_QUAL_OUT(sale),
    .STRAP_STROBE_LOW_OUT(slow), .REFUSED_OUT(refd), .INT_REQ_OUT(req),
    .INT_WE_OUT(we), .INT_SPACE_OUT(sp), .INT_ADDR_OUT(ia),
    .INT_WDATA_OUT(wd), .INT_GNT_IN(gnt), .INT_DONE_IN(done),
    .INT_RDATA_IN(rdat), .CORE_STALL_OUT(stall));

  hsp_host_model u_host (
    .clk_in(clk), .ack_in(ack), .pol_in(pol), .bus_in(bus),
    .drv_out(drv), .msb_out(msb), .ale_out(ale), .rd_n_out(rdn),
    .wr_n_out(wrn), .ms_n_out(msn), .io_n_out(ion), .to_out(to));

  // memory stub: grant comes after a random wait, so the port must queue
  always @(posedge clk) begin
    lf <= {lf[6:0], lf[7] ^ lf[5]};
    gnt <= req && !gnt && lf[0];
    done <= gnt;
    if (gnt) rdat <= mem[ia[7:0]];
    if (gnt && we) begin
      mem[ia[7:0]] <= wd;
      wa <= ia;
      wv <= wd;
      wcnt <= wcnt + 1;
    end
    scnt <= scnt + int'(stall);
    rcnt <= rcnt + int'(refd);
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [24:0] ea(input logic [16:0] a);
    return {page, t24 ? {1'b0, a[16:2]} : a[16:1]};
  endfunction

  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (!ok) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cfgw;
    cwr <= 1'b1;
    @(posedge clk);
    cwr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wwait(input int c);
    int n;
    n = 0;
    while (wcnt != c && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(wcnt == c, "internal write missing");
    if (wcnt != c)
      wrap_up();
    else
      repeat (2) @(posedge clk);
  endtask
  // pieces taken from lanes f.. of the packet word, low lane first unless be is set
  task automatic xfer(input logic wr, input logic [16:0] a, input int f,
                      input int np, input logic [31:0] b,
                      output logic [31:0] q);
    logic [15:0] rd;
    int w, ln;
    w = b16 ? 16 : 8;
    q = '0;
    if (!dm) u_host.addr(a);
    for (int k = f; k < f + np; k++) begin
      // reversed order walks the same lanes from the top down
      ln = be ? 2 * f + np - 1 - k : k;
      u_host.acc(wr, 16'(b >> (ln * w)), rd);
      q |= 32'(b16 ? rd : {8'h00, rd[7:0]}) << (ln * w);
    end
  endtask

  always @(posedge to) begin
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    logic [31:0] q, b;
    logic [23:0] v;
    logic [16:0] a;
    logic [1:0] lo;
    int m, wc;
    wc = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk(bo === 1'b0 && slow === 1'b1 && sale === 1'b0, "straps");
    // not ready while no select is active
    chk(busy === 1'b0 && oe === 1'b0 && ack === 1'b0, "idle");
    u_host.sel(1, 0);
    for (int i = 0; i < 20; i++) begin
      m = i % 5;
      seed = xs(seed);
      r = seed;
      seed = xs(seed);
      v = seed[23:0];
      b16 <= (m == 1 || m == 4);
      t24 <= (m >= 2);
      p4 <= (m == 3);
      boot <= r[20];
      be <= r[21];
      page <= r[31:23];
      cfgw();
      chk(bo === b16, "bus width");
      lo = (m == 2) ? 2'h1 : (m == 1) ? r[1:0] :
           (m == 0) ? {r[1], 1'b0} : (m == 4) ? {1'b0, r[0]} : 2'h0;
      a = {r[16:2], lo};
      b = t24 ? {v, 8'h00} : {16'h0000, v[15:0]};
      xfer(1, a, mf[m], mn[m], b, q);
      wc++;
      wwait(wc);
      chk(wa === ea(a) && sp === {1'b0, boot}, "write address");
      chk(t24 ? wv === v : wv === {8'h00, v[15:0]}, "write data");
      xfer(0, a, mf[m], mn[m], b, q);
      chk(t24 ? q[31:8] === v : q[15:0] === v[15:0], "read back");
      chk(scnt == 2 * (i + 1), "core stall count");
    end
    b16 <= 1'b1;
    t24 <= 1'b0;
    iopg <= 6'h00;
    cfgw();
    u_host.sel(0, 1);
    xfer(1, 17'h00010, 0, 1, 32'h1234, q);
    repeat (4) @(posedge clk);
    chk(rcnt == 1 && wcnt == wc, "io page 0 reached");
    iopg <= 6'h3f;
    cfgw();
    xfer(1, 17'h00010, 0, 1, 32'h1234, q);
    wc++;
    wwait(wc);
    chk(wa === {3'h0, 6'h3f, 16'h0008} && sp === 2'h2, "io page 63");
    chk(scnt == 40, "io access stalled core");
    u_host.sel(1, 1);
    xfer(1, 17'h00010, 0, 1, 32'h1234, q);
    repeat (4) @(posedge clk);
    chk(rcnt == 2 && wcnt == wc, "two selects served");
    u_host.sel(0, 0);
    @(posedge clk);
    chk(ack === 1'b0 && oe === 1'b0, "deselect");
    u_host.sel(1, 0);
    dm <= 1'b1;
    cfgw();
    daddr <= 16'h0100;
    dcnt <= 16'h0002;
    dload <= 1'b1;
    @(posedge clk);
    dload <= 1'b0;
    @(posedge clk);
    chk(busy === 1'b1, "dma not busy");
    for (int k = 0; k < 2; k++) begin
      xfer(1, 17'h0, 0, 1, 32'habcd + k, q);
      wc++;
      wwait(wc);
      chk(wa === {page, 16'(16'h0100 + k)}, "dma address");
    end
    chk(busy === 1'b0, "dma count end");
    dcnt <= 16'h0001;
    dload <= 1'b1;
    @(posedge clk);
    dload <= 1'b0;
    u_host.sel(0, 1);
    xfer(1, 17'h0, 0, 1, 32'h5555, q);
    repeat (4) @(posedge clk);
    chk(rcnt == 3 && wcnt == wc, "dma io served");
    pol <= 1'b0;
    u_host.sel(1, 0);
    dm <= 1'b0;
    cfgw();
    chk(ack === 1'b0, "ack polarity");
    xfer(1, 17'h00020, 0, 1, 32'h0f0f, q);
    wc++;
    wwait(wc);
    wrap_up();
  end
endmodule
